// file: uic_cfg.svh
// constants for the universal input conditioning block
// Functional notes
// - source codes 0..8 decode to block kinds
// - codes 9..11 depend on feedback variant
// - input type 0..6 steers processing
// - range bit only for voltage, current
// - pull-down load only voltage 0-5 V
// - converter rejection filter, default 50 Hz
// - per-input range and error limits held
// - digital pull: none, up, down
// - logic type 0..4, normal by default
// - normal follows signal, inverse negates it
// - latched toggles on off-to-on
// - inverse latched toggles on on-to-off
// - frequency/pulse pre-filter 0/111ns/1.78us/14.22us
// - teeth_per_turn above zero gives rpm
// - post-filter none, moving, repeating; default none
// - no filter passes latest measurement
// - moving average every 1 ms
// - repeating average over N readings
// - error clears only past hysteresis
// - supply and temperature thresholds flag
// - global diagnostic mode off/nonblank/normal
// - block diagnostic broadcast enable
`ifndef UIC_CFG_SVH
`define UIC_CFG_SVH
`define UIC_CLK_NS      8
`define UIC_TICK_NS     1000000
`define UIC_TICK_CYC    (`UIC_TICK_NS / `UIC_CLK_NS)
`define UIC_PF1_NS      111
`define UIC_PF2_NS      1780
`define UIC_PF3_NS      14220
`define UIC_PF1_CYC     ((`UIC_PF1_NS + `UIC_CLK_NS - 1) / `UIC_CLK_NS)
`define UIC_PF2_CYC     ((`UIC_PF2_NS + `UIC_CLK_NS - 1) / `UIC_CLK_NS)
`define UIC_PF3_CYC     ((`UIC_PF3_NS + `UIC_CLK_NS - 1) / `UIC_CLK_NS)
`define UIC_OFS_GCTRL   12'h000
`define UIC_OFS_UVTH    12'h004
`define UIC_OFS_OVTH    12'h008
`define UIC_OFS_OTTH    12'h00C
`define UIC_OFS_SRCSEL  12'h010
`define UIC_OFS_STATUS  12'h014
`define UIC_CH_REGION   5'h01
`define UIC_CH_CFG      3'd0
`define UIC_CH_EMIN     3'd1
`define UIC_CH_EMAX     3'd2
`define UIC_CH_HYST     3'd3
`define UIC_CH_RANGE    3'd4
`define UIC_CH_DEB      3'd5
`define UIC_CH_FILT     3'd6
`define UIC_CH_VAL      3'd7
`define UIC_CFG_RST     32'h0000_0220
`define UIC_GCTRL_RST   32'h0000_0006
`define UIC_DEB_RST     16'h00FF
`define UIC_FILT_RST    24'h00_0001
`define UIC_EMAX_RST    16'hFFFF
`endif

// file: uic_pkg.sv
// types of the universal input conditioning block
package uic_pkg;
	typedef enum logic [2:0] {IT_OFF, IT_VOLT, IT_CURR, IT_DIG, IT_FREQ,
		IT_PWM, IT_RES} uic_itype_e;
	typedef enum logic [2:0] {LG_NONE, LG_NORM, LG_INV, LG_LATCH,
		LG_INVLATCH} uic_logic_e;
	typedef enum logic [1:0] {DF_NONE, DF_MOVING, DF_REPEAT} uic_dfilt_e;
	typedef enum logic [1:0] {DM_OFF, DM_NONBLANK, DM_NORMAL} uic_dmode_e;
	typedef enum logic [3:0] {SRC_UNUSED, SRC_UIN, SRC_BUSRX, SRC_CONST,
		SRC_MATH, SRC_PLOGIC, SRC_LUT, SRC_COND, SRC_LATCH, SRC_REFFB,
		SRC_SUPPLY, SRC_TEMP, SRC_INVALID} uic_src_e;
	typedef struct packed {
		logic [15:0] rsv;
		logic [1:0]  dfilt;
		logic [1:0]  pwmf;
		logic [2:0]  lgc;
		logic [1:0]  pull;
		logic [1:0]  afilt;
		logic        pdown;
		logic        rng;
		logic [2:0]  itype;
	} uic_cfg_s;
	typedef struct packed {
		logic        state;
		logic        pf_level;
		logic        pullup_en;
		logic        pulldown_en;
		logic        load_en;
		logic        range_sel;
		logic [1:0]  afilt_sel;
		logic        err_lo;
		logic        err_hi;
		logic [15:0] value;
	} uic_ch_s;
	typedef struct packed {
		logic        diag_en;
		logic        nonblank_only;
		logic        uv;
		logic        ov;
		logic        ot;
		logic        blk_diag_tx;
	} uic_diag_s;
endpackage

// file: uic_top.sv
// universal input conditioning with axi4-lite setup registers
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "uic_cfg.svh"
module uic_top import uic_pkg::*; #(
	parameter int TICK_CYC = `UIC_TICK_CYC
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [11:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [11:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [3:0]        pin_in,
	input  wire logic [3:0]        meas_valid,
	input  wire logic [3:0][15:0]  meas,
	input  wire logic [15:0]       supply_val,
	input  wire logic [15:0]       temp_val,
	input  wire logic              blk_diag_req,
	output uic_ch_s   [3:0]        ch,
	output uic_diag_s              diag,
	output uic_src_e               src_kind
);
	logic [11:0]          aw_addr_r;
	logic                 aw_have_r;
	logic [31:0]          w_data_r;
	logic [3:0]           w_strb_r;
	logic                 w_have_r;
	logic                 wr_go;
	logic                 wr_ch;
	logic                 rd_ch;
	logic [31:0]          rd_nxt;
	logic                 rd_ok;
	logic [31:0]          gctrl_r;
	logic [15:0]          uv_r;
	logic [15:0]          ov_r;
	logic [15:0]          ot_r;
	logic [3:0]           srcsel_r;
	uic_cfg_s  [3:0]      cfg_r;
	logic [3:0][15:0]     emin_r;
	logic [3:0][15:0]     emax_r;
	logic [3:0][15:0]     hyst_r;
	logic [3:0][31:0]     rng_r;
	logic [3:0][15:0]     deb_r;
	logic [3:0][23:0]     filt_r;
	logic [16:0]          tick_cnt_r;
	logic                 tick_r;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				m[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return m;
	endfunction

	// write side: address and data are taken in either order
	assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
	assign wr_ch = aw_addr_r[11:7] == `UIC_CH_REGION;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			aw_addr_r     <= 12'h000;
			w_data_r      <= 32'h0000_0000;
			w_strb_r      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end else begin
			s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_have_r    <= 1'b0;
				w_have_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_ch || aw_addr_r <= `UIC_OFS_SRCSEL)
					? 2'h0 : 2'h2;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// global registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gctrl_r  <= `UIC_GCTRL_RST;
			uv_r     <= 16'h0000;
			ov_r     <= 16'hFFFF;
			ot_r     <= 16'hFFFF;
			srcsel_r <= 4'h0;
		end else if (wr_go && !wr_ch) begin
			unique case (aw_addr_r)
				`UIC_OFS_GCTRL:  gctrl_r <= merge(gctrl_r, w_data_r, w_strb_r);
				`UIC_OFS_UVTH:   uv_r <= 16'(merge({16'h0, uv_r}, w_data_r,
					w_strb_r));
				`UIC_OFS_OVTH:   ov_r <= 16'(merge({16'h0, ov_r}, w_data_r,
					w_strb_r));
				`UIC_OFS_OTTH:   ot_r <= 16'(merge({16'h0, ot_r}, w_data_r,
					w_strb_r));
				`UIC_OFS_SRCSEL: srcsel_r <= 4'(merge({28'h0, srcsel_r},
					w_data_r, w_strb_r));
				default: ;
			endcase
		end
	end

	// read side: one read at a time, answer one cycle after address
	assign rd_ch = s_axi_araddr[11:7] == `UIC_CH_REGION;
	always_comb begin
		rd_nxt = 32'h0000_0000;
		rd_ok  = 1'b1;
		if (rd_ch) begin
			unique case (s_axi_araddr[4:2])
				`UIC_CH_CFG:   rd_nxt = cfg_r[s_axi_araddr[6:5]];
				`UIC_CH_EMIN:  rd_nxt = {16'h0, emin_r[s_axi_araddr[6:5]]};
				`UIC_CH_EMAX:  rd_nxt = {16'h0, emax_r[s_axi_araddr[6:5]]};
				`UIC_CH_HYST:  rd_nxt = {16'h0, hyst_r[s_axi_araddr[6:5]]};
				`UIC_CH_RANGE: rd_nxt = rng_r[s_axi_araddr[6:5]];
				`UIC_CH_DEB:   rd_nxt = {16'h0, deb_r[s_axi_araddr[6:5]]};
				`UIC_CH_FILT:  rd_nxt = {8'h0, filt_r[s_axi_araddr[6:5]]};
				`UIC_CH_VAL:   rd_nxt = {ch[s_axi_araddr[6:5]].err_hi,
					ch[s_axi_araddr[6:5]].err_lo,
					ch[s_axi_araddr[6:5]].state, 13'h0,
					ch[s_axi_araddr[6:5]].value};
			endcase
		end else begin
			unique case (s_axi_araddr)
				`UIC_OFS_GCTRL:  rd_nxt = gctrl_r;
				`UIC_OFS_UVTH:   rd_nxt = {16'h0, uv_r};
				`UIC_OFS_OVTH:   rd_nxt = {16'h0, ov_r};
				`UIC_OFS_OTTH:   rd_nxt = {16'h0, ot_r};
				`UIC_OFS_SRCSEL: rd_nxt = {28'h0, srcsel_r};
				`UIC_OFS_STATUS: rd_nxt = {21'h0, diag.ot, diag.ov, diag.uv,
					4'(src_kind), 4'h0};
				default:         rd_ok = 1'b0;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_nxt;
				s_axi_rresp   <= rd_ok ? 2'h0 : 2'h2;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// 1 ms filter tick shared by all inputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_r <= 17'h0;
			tick_r     <= 1'b0;
		end else begin
			tick_r     <= tick_cnt_r == 17'(TICK_CYC - 1);
			tick_cnt_r <= (tick_cnt_r == 17'(TICK_CYC - 1)) ? 17'h0
				: tick_cnt_r + 17'h1;
		end
	end

	// source selector decode, codes 9 and 10 shift by one without feedback
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_kind <= SRC_UNUSED;
		end else if (srcsel_r <= 4'h8) begin
			src_kind <= uic_src_e'(srcsel_r);
		end else if (gctrl_r[3]) begin
			src_kind <= (srcsel_r <= 4'hB) ? uic_src_e'(srcsel_r)
				: SRC_INVALID;
		end else begin
			src_kind <= (srcsel_r <= 4'hA) ? uic_src_e'(srcsel_r + 4'h1)
				: SRC_INVALID;
		end
	end

	// supply, temperature and global diagnostic mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			diag <= '0;
		end else begin
			diag.uv <= supply_val < uv_r;
			diag.ov <= supply_val > ov_r;
			diag.ot <= temp_val >= ot_r;
			diag.diag_en       <= gctrl_r[1:0] != 2'(DM_OFF);
			diag.nonblank_only <= gctrl_r[1:0] == 2'(DM_NONBLANK);
			diag.blk_diag_tx   <= blk_diag_req && gctrl_r[2]
				&& gctrl_r[1:0] != 2'(DM_OFF);
		end
	end

	for (genvar i = 0; i < 4; i++) begin : g_ch
		logic        s1_r;
		logic        s2_r;
		logic [15:0] db_cnt_r;
		logic        db_r;
		logic        db_prev_r;
		logic [10:0] pf_cnt_r;
		logic [10:0] pf_len;
		logic [15:0] raw_r;
		logic [23:0] sum_r;
		logic [7:0]  n_cnt_r;
		logic [7:0]  fc;
		logic [16:0] diff;
		logic [16:0] step;
		logic [23:0] total;
		logic [21:0] rpm;
		logic        wr_me;
		logic        analog;
		uic_cfg_s    c;

		assign c      = cfg_r[i];
		assign wr_me  = wr_go && wr_ch && aw_addr_r[6:5] == 2'(i);
		assign fc     = (filt_r[i][7:0] == 8'h0) ? 8'h1 : filt_r[i][7:0];
		assign diff   = {1'b0, raw_r} - {1'b0, ch[i].value};
		assign step   = 17'($signed(diff) / $signed({9'h0, fc}));
		assign total  = sum_r + {8'h0, raw_r};
		assign rpm    = 22'(({6'h0, meas[i]} * 22'd60)
			/ {6'h0, filt_r[i][23:8]});
		assign analog = c.itype == IT_VOLT || c.itype == IT_CURR;

		always_comb begin
			unique case (c.pwmf)
				2'd1:    pf_len = 11'(`UIC_PF1_CYC);
				2'd2:    pf_len = 11'(`UIC_PF2_CYC);
				2'd3:    pf_len = 11'(`UIC_PF3_CYC);
				default: pf_len = 11'h0;
			endcase
		end

		// setup registers of this input
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cfg_r[i]  <= `UIC_CFG_RST;
				emin_r[i] <= 16'h0000;
				emax_r[i] <= `UIC_EMAX_RST;
				hyst_r[i] <= 16'h0000;
				rng_r[i]  <= 32'hFFFF_0000;
				deb_r[i]  <= `UIC_DEB_RST;
				filt_r[i] <= `UIC_FILT_RST;
			end else if (wr_me) begin
				unique case (aw_addr_r[4:2])
					`UIC_CH_CFG:   cfg_r[i] <= merge(cfg_r[i], w_data_r,
						w_strb_r);
					`UIC_CH_EMIN:  emin_r[i] <= 16'(merge({16'h0, emin_r[i]},
						w_data_r, w_strb_r));
					`UIC_CH_EMAX:  emax_r[i] <= 16'(merge({16'h0, emax_r[i]},
						w_data_r, w_strb_r));
					`UIC_CH_HYST:  hyst_r[i] <= 16'(merge({16'h0, hyst_r[i]},
						w_data_r, w_strb_r));
					`UIC_CH_RANGE: rng_r[i] <= merge(rng_r[i], w_data_r,
						w_strb_r);
					`UIC_CH_DEB:   deb_r[i] <= 16'(merge({16'h0, deb_r[i]},
						w_data_r, w_strb_r));
					`UIC_CH_FILT:  filt_r[i] <= 24'(merge({8'h0, filt_r[i]},
						w_data_r, w_strb_r));
					default: ;
				endcase
			end
		end

		// pin synchroniser, then debounce and pre-filter
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				s1_r      <= 1'b0;
				s2_r      <= 1'b0;
				db_cnt_r  <= 16'h0;
				db_r      <= 1'b0;
				db_prev_r <= 1'b0;
				pf_cnt_r  <= 11'h0;
			end else begin
				s1_r      <= pin_in[i];
				s2_r      <= s1_r;
				db_prev_r <= db_r;
				if (s2_r == db_r) begin
					db_cnt_r <= 16'h0;
				end else if (db_cnt_r >= deb_r[i]) begin
					db_r     <= s2_r;
					db_cnt_r <= 16'h0;
				end else begin
					db_cnt_r <= db_cnt_r + 16'h1;
				end
				if (s2_r == ch[i].pf_level) begin
					pf_cnt_r <= 11'h0;
				end else begin
					pf_cnt_r <= pf_cnt_r + 11'h1;
				end
			end
		end

		// pin controls, digital state, errors and value
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ch[i]   <= '0;
				raw_r   <= 16'h0;
				sum_r   <= 24'h0;
				n_cnt_r <= 8'h0;
			end else begin
				ch[i].pullup_en   <= c.itype == IT_DIG && c.pull == 2'd1;
				ch[i].pulldown_en <= c.itype == IT_DIG && c.pull == 2'd2;
				ch[i].load_en     <= c.itype == IT_VOLT && !c.rng
					&& c.pdown;
				ch[i].range_sel   <= analog && c.rng;
				ch[i].afilt_sel   <= analog ? c.afilt : 2'd0;
				if ((c.itype == IT_FREQ || c.itype == IT_PWM)
					&& pf_cnt_r >= pf_len) begin
					ch[i].pf_level <= s2_r;
				end
				if (c.itype != IT_DIG) begin
					ch[i].state <= 1'b0;
				end else begin
					unique case (c.lgc)
						LG_NORM:     ch[i].state <= db_r;
						LG_INV:      ch[i].state <= !db_r;
						LG_LATCH:    if (db_r && !db_prev_r) begin
							ch[i].state <= !ch[i].state;
						end
						LG_INVLATCH: if (!db_r && db_prev_r) begin
							ch[i].state <= !ch[i].state;
						end
						default:     ch[i].state <= 1'b0;
					endcase
				end
				if (meas_valid[i]) begin
					raw_r <= (c.itype == IT_FREQ && filt_r[i][23:8] != 16'h0)
						? ((rpm > 22'h00FFFF) ? 16'hFFFF : rpm[15:0])
						: meas[i];
				end
				// the filters only act on converter inputs
				if (c.itype == IT_OFF || c.itype == IT_DIG) begin
					ch[i].value <= 16'h0;
				end else if (!analog || c.dfilt == 2'(DF_NONE)) begin
					ch[i].value <= raw_r;
				end else if (tick_r && c.dfilt == 2'(DF_MOVING)) begin
					ch[i].value <= 16'(ch[i].value + step[15:0]);
				end else if (tick_r && c.dfilt == 2'(DF_REPEAT)) begin
					if (n_cnt_r + 8'h1 >= fc) begin
						ch[i].value <= 16'(total / {16'h0, fc});
						sum_r       <= 24'h0;
						n_cnt_r     <= 8'h0;
					end else begin
						sum_r   <= total;
						n_cnt_r <= n_cnt_r + 8'h1;
					end
				end
				if (c.itype == IT_OFF || c.itype == IT_DIG) begin
					ch[i].err_lo <= 1'b0;
					ch[i].err_hi <= 1'b0;
				end else begin
					if (ch[i].value < emin_r[i]) begin
						ch[i].err_lo <= 1'b1;
					end else if ({1'b0, ch[i].value} >=
						{1'b0, emin_r[i]} + {1'b0, hyst_r[i]}) begin
						ch[i].err_lo <= 1'b0;
					end
					if (ch[i].value > emax_r[i]) begin
						ch[i].err_hi <= 1'b1;
					end else if ({1'b0, ch[i].value} + {1'b0, hyst_r[i]}
						<= {1'b0, emax_r[i]}) begin
						ch[i].err_hi <= 1'b0;
					end
				end
			end
		end
	end
endmodule

// file: uic_top_asserts.sv
// port assertions for the input conditioning block
`timescale 1ns/10ps
module uic_top_asserts import uic_pkg::*; (
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic          s_axi_awvalid,
	input wire logic          s_axi_awready,
	input wire logic          s_axi_wvalid,
	input wire logic          s_axi_wready,
	input wire logic [1:0]    s_axi_bresp,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_bready,
	input wire logic          s_axi_arvalid,
	input wire logic          s_axi_arready,
	input wire logic [31:0]   s_axi_rdata,
	input wire logic          s_axi_rvalid,
	input wire logic          s_axi_rready,
	input wire logic [3:0]    pin_in,
	input wire logic          blk_diag_req,
	input wire uic_ch_s [3:0] ch,
	input wire uic_diag_s     diag
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wr_answer;
		##[1:3] s_axi_bvalid;
	endsequence
	property p_wr_ans; s_wr_taken |-> s_wr_answer; endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_tx;
		diag.blk_diag_tx |-> diag.diag_en && $past(blk_diag_req);
	endproperty
	a_tx: assert property (p_tx) else $error("broadcast without cause");
	property p_nonblank; diag.nonblank_only |-> diag.diag_en; endproperty
	a_nonblank: assert property (p_nonblank) else $error("bad mode");
	property p_load;
		ch[0].load_en |-> !ch[0].range_sel && !ch[0].pullup_en;
	endproperty
	a_load: assert property (p_load) else $error("load in wrong range");
	property p_pull; !(ch[0].pullup_en && ch[0].pulldown_en); endproperty
	a_pull: assert property (p_pull) else $error("both pulls on");
	property p_err; !(ch[0].err_lo && ch[0].err_hi); endproperty
	a_err: assert property (p_err) else $error("both errors set");
	// a state edge needs the pin unchanged from three to two cycles before it, glitches never pass
	property p_dbn;
		$changed(ch[1].state) |-> $past(pin_in[1], 2) == $past(pin_in[1], 3);
	endproperty
	a_dbn: assert property (p_dbn) else $error("state followed glitch");
endmodule

bind uic_top uic_top_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_in, .blk_diag_req,
	.ch, .diag);

// file: uic_sensor.sv
// behavioural sensors and switches on the four inputs
`timescale 1ns/10ps
module uic_sensor (
	input  wire logic       aclk,
	output logic [3:0]       pin_in,
	output logic [3:0]       meas_valid,
	output logic [3:0][15:0] meas
);
	initial begin
		pin_in = '0;
		meas_valid = '0;
		meas = '0;
	end
	// data is only good in its valid cycle, so it turns to garbage after
	task automatic send(input int i, input logic [15:0] v);
		@(posedge aclk);
		meas[i] <= v;
		meas_valid[i] <= 1'b1;
		@(posedge aclk);
		meas_valid[i] <= 1'b0;
		meas[i] <= ~v;
	endtask
	task automatic level(input int i, input logic l, input int n);
		@(posedge aclk);
		pin_in[i] <= l;
		repeat (n) @(posedge aclk);
		#1;
	endtask
endmodule

// file: tb_top.sv
// self-checking bench for the input conditioning block
`timescale 1ns/10ps
`include "uic_cfg.svh"
module tb_top import uic_pkg::*; ;
	logic             aclk = 1'b0;
	logic             aresetn = 1'b0;
	logic [11:0]      s_axi_awaddr = '0;
	logic [11:0]      s_axi_araddr = '0;
	logic [31:0]      s_axi_wdata = '0;
	logic [3:0]       s_axi_wstrb = '0;
	logic             s_axi_awvalid = 1'b0;
	logic             s_axi_wvalid = 1'b0;
	logic             s_axi_bready = 1'b0;
	logic             s_axi_arvalid = 1'b0;
	logic             s_axi_rready = 1'b0;
	logic             s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic             s_axi_arready, s_axi_rvalid;
	logic [1:0]       s_axi_bresp, s_axi_rresp;
	logic [31:0]      s_axi_rdata;
	logic [3:0]       pin_in, meas_valid;
	logic [3:0][15:0] meas;
	logic [15:0]      supply_val = '0;
	logic [15:0]      temp_val = '0;
	logic             blk_diag_req = 1'b0;
	uic_ch_s [3:0]    ch;
	uic_diag_s        diag;
	uic_src_e         src_kind;
	int               fail_count = 0;
	int               n_compared = 0;
	int               cyc = 0;
	logic             s0;
	wire [17:0]       ch0_ev = {ch[0].err_lo, ch[0].err_hi, ch[0].value};
	logic [11:0] rst_a [7] = '{12'h000, 12'h008, 12'h00C, 12'h080, 12'h088,
		12'h094, 12'h098};
	logic [31:0] rst_v [7] = '{32'h6, 32'hFFFF, 32'hFFFF, 32'h220, 32'hFFFF,
		32'hFF, 32'h1};
	logic [15:0] sv [4] = '{16'h00FF, 16'h0100, 16'h0200, 16'h0201};
	logic [15:0] tv [4] = '{16'h004F, 16'h0050, 16'h0000, 16'h0000};
	logic [2:0]  dv [4] = '{3'h4, 3'h1, 3'h0, 3'h2};
	logic [15:0] cf [5] = '{16'h0071, 16'h00D9, 16'h002A, 16'h008B, 16'h0103};
	logic [5:0]  cx [5] = '{6'h0B, 6'h06, 6'h05, 6'h20, 6'h10};
	logic [15:0] mv [7] = '{16'h0200, 16'h00FF, 16'h0105, 16'h0110, 16'h0301,
		16'h02F5, 16'h02F0};
	logic [1:0]  ev [7] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h1, 2'h1, 2'h0};
	int          pfl [3] = '{`UIC_PF1_CYC, `UIC_PF2_CYC, `UIC_PF3_CYC};

	always #4 aclk = ~aclk;

	uic_top #(.TICK_CYC(20)) uut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in,
		.meas_valid, .meas, .supply_val, .temp_val, .blk_diag_req, .ch,
		.diag, .src_kind);
	uic_sensor sens (.aclk, .pin_in, .meas_valid, .meas);

	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_out(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (s_axi_awready && !ad) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && !wd) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid) @(posedge aclk);
		s_axi_bready <= 1'b0;
		chk_reg(32'(s_axi_bresp), 32'(er));
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk_reg(s_axi_rdata, e);
		chk_reg(32'(s_axi_rresp), 32'(er));
	endtask
	task automatic cyc_wait(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask
	task automatic next_val(input logic [15:0] e);
		logic [15:0] o;
		int n;
		o = ch[0].value;
		n = 0;
		do begin
			cyc_wait(1);
			n++;
		end while (ch[0].value === o && n < 100);
		chk_out(32'(ch[0].value), 32'(e));
	endtask
	function automatic logic [3:0] exp_src(input int b, input int c);
		if (c <= 8 || (b == 1 && c <= 11)) return 4'(c);
		if (b == 0 && c <= 10) return 4'(c + 1);
		return 4'hC;
	endfunction
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// the whole run is near 8000 cycles, so this only trips on a hang
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fail_count++;
			summarize();
		end
	end

	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 7; i++) rd(rst_a[i], rst_v[i], 2'h0);
		rd(12'h040, 32'h0, 2'h2);
		wr(12'h040, 32'h1, 2'h2);
		wr(12'h014, 32'h0, 2'h2);
		done("registers");
		for (int b = 0; b < 2; b++) begin
			wr(12'h000, 32'(6 + 8 * b), 2'h0);
			for (int c = 0; c < 16; c++) begin
				wr(12'h010, 32'(c), 2'h0);
				cyc_wait(3);
				chk_out(32'(src_kind), 32'(exp_src(b, c)));
			end
		end
		rd(12'h014, 32'h0000_00C0, 2'h0);
		@(posedge aclk);
		blk_diag_req <= 1'b1;
		for (int m = 0; m < 3; m++) for (int e = 0; e < 2; e++) begin
			wr(12'h000, 32'(m + 4 * e), 2'h0);
			cyc_wait(3);
			chk_out(32'({diag.diag_en, diag.nonblank_only, diag.blk_diag_tx}),
				32'({m != 0, m == 1, m != 0 && e == 1}));
		end
		wr(12'h004, 32'h100, 2'h0);
		wr(12'h008, 32'h200, 2'h0);
		wr(12'h00C, 32'h50, 2'h0);
		for (int i = 0; i < 4; i++) begin
			@(posedge aclk);
			supply_val <= sv[i];
			temp_val <= tv[i];
			cyc_wait(3);
			chk_out(32'({diag.uv, diag.ov, diag.ot}), 32'(dv[i]));
		end
		done("globals");
		for (int i = 0; i < 5; i++) begin
			wr(12'h080, 32'(cf[i]), 2'h0);
			cyc_wait(3);
			chk_out(32'(ch[0][23:18]), 32'(cx[i]));
		end
		wr(12'h080, 32'h1, 2'h0);
		wr(12'h084, 32'h100, 2'h0);
		wr(12'h088, 32'h300, 2'h0);
		wr(12'h08C, 32'h10, 2'h0);
		for (int i = 0; i < 7; i++) begin
			sens.send(0, mv[i]);
			cyc_wait(3);
			chk_out(32'(ch0_ev), 32'({ev[i], mv[i]}));
		end
		sens.send(0, 16'h0000);
		cyc_wait(3);
		wr(12'h098, 32'h2, 2'h0);
		wr(12'h080, 32'h4001, 2'h0);
		sens.send(0, 16'h0100);
		next_val(16'h0080);
		next_val(16'h00C0);
		wr(12'h080, 32'h8001, 2'h0);
		next_val(16'h0100);
		sens.send(0, 16'h0200);
		cyc_wait(5);
		chk_out(32'(ch[0].value), 32'h100);
		next_val(16'h0200);
		done("analog");
		wr(12'h0B4, 32'h4, 2'h0);
		wr(12'h0D4, 32'h4, 2'h0);
		wr(12'h0A0, 32'h203, 2'h0);
		wr(12'h0C0, 32'h403, 2'h0);
		sens.level(1, 1'b1, 2);
		sens.level(1, 1'b0, 15);
		chk_out(32'(ch[1].state), 32'h0);
		for (int i = 0; i < 4; i++) begin
			sens.level(1, !i[0], 0);
			sens.level(2, !i[0], 15);
			chk_out(32'({ch[1].state, ch[2].state}), 32'({!i[0], i[0]}));
		end
		wr(12'h0A0, 32'h603, 2'h0);
		wr(12'h0C0, 32'h803, 2'h0);
		cyc_wait(4);
		s0 = ch[2].state;
		for (int i = 0; i < 4; i++) begin
			sens.level(1, !i[0], 0);
			sens.level(2, !i[0], 15);
			chk_out(32'(ch[1].state), 32'(i < 2));
			chk_out(32'(ch[2].state), 32'(s0 ^ (i > 0 && i < 3)));
		end
		done("digital");
		for (int i = 0; i < 3; i++) begin
			wr(12'h0E0, 32'(4 + 4096 * (i + 1)), 2'h0);
			sens.level(3, 1'b1, pfl[i] / 2);
			chk_out(32'(ch[3].pf_level), 32'h0);
			sens.level(3, 1'b0, pfl[i] + 8);
			sens.level(3, 1'b1, pfl[i] + 8);
			chk_out(32'(ch[3].pf_level), 32'h1);
			sens.level(3, 1'b0, pfl[i] + 8);
		end
		wr(12'h0F8, 32'h201, 2'h0);
		sens.send(3, 16'h0064);
		cyc_wait(3);
		chk_out(32'(ch[3].value), 32'hBB8);
		wr(12'h0F8, 32'h1, 2'h0);
		sens.send(3, 16'h0064);
		cyc_wait(3);
		chk_out(32'(ch[3].value), 32'h64);
		done("pulse inputs");
		summarize();
	end
endmodule
